/* rtl/load_threshold_pkg.sv */
/*
 * Shared types and constants for the generator load threshold monitor.
 * Assumes a single 125 MHz clock and that power and settings are stable,
 * synchronous inputs supplied by the surrounding controller.
 */
// How it works
// R1: A mode input picks low-power monitoring with 0 and high-power monitoring with 1.
// R2: The monitoring result leaves the block as one registered digital output.
// R3: When the enable input is configured, monitoring runs only while it is active.
// R4: After each activation of the enable input the output stays off for the initial delay.
// R5: Both thresholds are percentages of the rated generator power.
// R6: Thresholds that are both zero or inconsistent disable the block and clear the output.
// R7: In low-power mode the output asserts on underload to switch in a dummy load.
// R8: In high-power mode the output asserts on heavy load to shed non-essential loads.
// R9: The configuring party keeps the switched load step inside the opposite threshold.
// R10: Assertion and release each need their condition held for the matching delay.
// R11: A delay timer restarts whenever its condition drops before the delay expires.
package load_threshold_pkg;

    // Monitoring modes.
    localparam logic MODE_LOW_POWER = 1'b0;
    localparam logic MODE_HIGH_POWER = 1'b1;

    // Width of power readings and settings.
    localparam int POWER_W = 16;
    localparam int PCT_W = 8;
    localparam int SEC_W = 16;

    // One second at the 125 MHz reference clock.
    localparam int CLK_HZ = 125_000_000;
    localparam int SEC_CYCLES = CLK_HZ;

    // Percent divisor for threshold scaling.
    localparam int PCT_FULL = 100;

    // Monitor state.
    typedef enum logic [1:0] {
        ST_DISABLED = 2'b00,
        ST_SETTLING = 2'b01,
        ST_IDLE = 2'b10,
        ST_ACTIVE = 2'b11
    } monitor_state_t;

    // Settings that travel together.
    typedef struct packed {
        logic mode;
        logic [PCT_W-1:0] low_pct;
        logic [PCT_W-1:0] high_pct;
        logic [SEC_W-1:0] init_delay_s;
        logic [SEC_W-1:0] low_delay_s;
        logic [SEC_W-1:0] high_delay_s;
        logic [POWER_W-1:0] rated_power;
    } monitor_cfg_t;

endpackage : load_threshold_pkg

/* rtl/second_timer.sv */
/*
 * Seconds timer: counts whole seconds while run is held and flags when
 * the programmed count is reached. Assumes a synchronous run input.
 */
`timescale 1ns/1ps
module second_timer #(
    parameter int TICK_CYCLES = load_threshold_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_run,
    input wire logic [load_threshold_pkg::SEC_W-1:0] i_limit_s,
    // Status
    output logic o_done
);
    // One second step, sized to the seconds counter so the increment never pads.
    localparam logic [load_threshold_pkg::SEC_W-1:0] SEC_ONE =
        {{(load_threshold_pkg::SEC_W-1){1'b0}}, 1'b1};
    logic [31:0] tick;
    logic [load_threshold_pkg::SEC_W-1:0] secs;

    // Dropping run clears both counters, so a broken condition starts over.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick <= 32'h0000_0000;
            secs <= '0;
        end else if (!i_run) begin
            tick <= 32'h0000_0000;
            secs <= '0;
        end else if (secs != i_limit_s) begin
            if (tick == 32'(TICK_CYCLES - 1)) begin
                tick <= 32'h0000_0000;
                secs <= secs + SEC_ONE;
            end else begin
                tick <= tick + 32'h0000_0001;
            end
        end
    end

    // Done while running and the whole count has elapsed; a zero limit is immediate.
    assign o_done = i_run && (secs == i_limit_s);
endmodule : second_timer

/* rtl/load_threshold_monitor.sv */
/*
 * Generator load threshold monitor: compares active power against two
 * percentage thresholds with qualifying delays and drives one output.
 * Assumes power and settings are synchronous and already filtered.
 */
`timescale 1ns/1ps
module load_threshold_monitor #(
    parameter int TICK_CYCLES = load_threshold_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Settings
    input wire load_threshold_pkg::monitor_cfg_t i_cfg,
    input wire logic i_enable_configured,
    // Live inputs
    input wire logic i_load_monitor_enable_input,
    input wire logic [load_threshold_pkg::POWER_W-1:0] i_active_power,
    // Result
    output logic o_load_threshold_output_function,
    output logic [1:0] o_state
);
    load_threshold_pkg::monitor_state_t state;
    load_threshold_pkg::monitor_state_t next_state;
    logic [31:0] low_lim;
    logic [31:0] high_lim;
    logic [31:0] pwr_x100;
    logic below_low;
    logic above_high;
    logic cfg_bad;
    logic gate_on;
    logic settle_run;
    logic settle_done;
    logic set_cond;
    logic clr_cond;
    logic set_done;
    logic clr_done;
    logic out_q;

    // R5 percent scaling: compare power*100 with pct*rated, avoiding a divider.
    assign pwr_x100 = 32'(i_active_power) * 32'(load_threshold_pkg::PCT_FULL);
    assign low_lim = 32'(i_cfg.low_pct) * 32'(i_cfg.rated_power);
    assign high_lim = 32'(i_cfg.high_pct) * 32'(i_cfg.rated_power);
    assign below_low = pwr_x100 < low_lim;
    assign above_high = pwr_x100 > high_lim;

    // R6 bad settings: both zero, or low not below high.
    assign cfg_bad = ((i_cfg.low_pct == '0) && (i_cfg.high_pct == '0))
        || (i_cfg.low_pct >= i_cfg.high_pct);

    // R3 enable gating: an unconfigured input counts as always active.
    assign gate_on = !i_enable_configured || i_load_monitor_enable_input;

    // Delay that qualifies one transition. Asserting waits for the delay of the side that
    // triggers the mode, releasing waits for the other one, so both timers share one decode.
    function automatic logic [load_threshold_pkg::SEC_W-1:0] pick_delay(
        input load_threshold_pkg::monitor_cfg_t cfg,
        input logic for_set
    );
        if ((cfg.mode == load_threshold_pkg::MODE_HIGH_POWER) == for_set) begin
            return cfg.high_delay_s;
        end
        return cfg.low_delay_s;
    endfunction : pick_delay

    // R1 R7 R8 mode steering: which side asserts and which releases.
    always_comb begin
        if (i_cfg.mode == load_threshold_pkg::MODE_LOW_POWER) begin
            set_cond = below_low;
            clr_cond = above_high;
        end else begin
            set_cond = above_high;
            clr_cond = below_low;
        end
    end

    // R4 initial delay runs only in settling, and only with an enable input.
    assign settle_run = (state == load_threshold_pkg::ST_SETTLING);

    second_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_settle (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_run(settle_run),
        .i_limit_s(i_cfg.init_delay_s),
        .o_done(settle_done)
    );

    // R10 R11 assert delay: restarts whenever the condition lapses.
    second_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_set (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_run((state == load_threshold_pkg::ST_IDLE) && set_cond),
        .i_limit_s(pick_delay(i_cfg, 1'b1)),
        .o_done(set_done)
    );

    // R10 R11 release delay: restarts whenever the condition lapses.
    second_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_clr (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_run((state == load_threshold_pkg::ST_ACTIVE) && clr_cond),
        .i_limit_s(pick_delay(i_cfg, 1'b0)),
        .o_done(clr_done)
    );

    // Next-state selection; disabling wins over everything else.
    always_comb begin
        next_state = state;
        case (state)
            load_threshold_pkg::ST_DISABLED: begin
                if (gate_on && !cfg_bad) begin
                    next_state = i_enable_configured ? load_threshold_pkg::ST_SETTLING
                        : load_threshold_pkg::ST_IDLE;
                end
            end
            load_threshold_pkg::ST_SETTLING: begin
                // R4 hold off until the settling time has passed.
                if (settle_done) begin
                    next_state = load_threshold_pkg::ST_IDLE;
                end
            end
            load_threshold_pkg::ST_IDLE: begin
                if (set_done) begin
                    next_state = load_threshold_pkg::ST_ACTIVE;
                end
            end
            load_threshold_pkg::ST_ACTIVE: begin
                if (clr_done) begin
                    next_state = load_threshold_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = load_threshold_pkg::ST_DISABLED;
            end
        endcase
        // R3 R6 an inactive enable or bad settings force the disabled state.
        if (!gate_on || cfg_bad) begin
            next_state = load_threshold_pkg::ST_DISABLED;
        end
    end

    // State register.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= load_threshold_pkg::ST_DISABLED;
        end else begin
            state <= next_state;
        end
    end

    // R2 registered output, high only in the active state.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_q <= 1'b0;
        end else begin
            out_q <= (next_state == load_threshold_pkg::ST_ACTIVE);
        end
    end

    assign o_load_threshold_output_function = out_q;
    assign o_state = state;
endmodule : load_threshold_monitor

/* bench/load_switch_model.sv */
/* Load switch model on the monitor output. Assumes one base power level from the bench. */
`timescale 1ns/1ps
module load_switch_model (
    // Inputs
    input wire logic i_switch,
    input wire logic i_mode,
    input wire logic [load_threshold_pkg::POWER_W-1:0] i_base_power,
    // Result
    output logic [load_threshold_pkg::POWER_W-1:0] o_power
);
    // small load step
    // The step of 100 stays inside the threshold gap, so the output cannot chatter.
    assign o_power = !i_switch ? i_base_power :
        (i_mode ? i_base_power - 16'h0064 : i_base_power + 16'h0064);
endmodule : load_switch_model

/* bench/load_threshold_monitor_props.sv */
/* Checker for the load threshold monitor. Assumes the bind below sees the top module ports. */
`timescale 1ns/1ps
module load_threshold_monitor_props #(
    parameter int TICK_CYCLES = 4
) (
    // Watched ports
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire load_threshold_pkg::monitor_cfg_t i_cfg,
    input wire logic i_enable_configured,
    input wire logic i_load_monitor_enable_input,
    input wire logic [load_threshold_pkg::POWER_W-1:0] i_active_power,
    input wire logic o_load_threshold_output_function,
    input wire logic [1:0] o_state
);
    logic bad, below, above, want, rel;
    int run, need;
    int settle_cnt;
    int init_need;
    assign init_need = int'(i_cfg.init_delay_s) * TICK_CYCLES;
    // Consecutive cycles spent in the settling state before this one.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            settle_cnt <= 0;
        end else begin
            settle_cnt <= (o_state == 2'b01) ? settle_cnt + 1 : 0;
        end
    end
    // Products in 32 bits, so a full scale reading never overflows.
    assign below = ({16'h0000, i_active_power} * 32'h0000_0064) <
        ({24'h00_0000, i_cfg.low_pct} * {16'h0000, i_cfg.rated_power});
    assign above = ({16'h0000, i_active_power} * 32'h0000_0064) >
        ({24'h00_0000, i_cfg.high_pct} * {16'h0000, i_cfg.rated_power});
    assign bad = (i_cfg.low_pct == 8'h00 && i_cfg.high_pct == 8'h00) ||
        (i_cfg.low_pct >= i_cfg.high_pct);
    assign want = i_cfg.mode ? above : below;
    assign rel = i_cfg.mode ? below : above;
    assign need = int'(i_cfg.mode ? i_cfg.high_delay_s : i_cfg.low_delay_s) * TICK_CYCLES;
    // Consecutive cycles the assert condition held before this one.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run <= 0;
        end else begin
            run <= want ? run + 1 : 0;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    property p_out; o_load_threshold_output_function == (o_state == 2'b11); endproperty
    a_out: assert property (p_out) else $error("output and state disagree");
    property p_bad; bad |=> o_state == 2'b00; endproperty
    a_bad: assert property (p_bad) else $error("bad thresholds not disabled");
    property p_gate; i_enable_configured && !i_load_monitor_enable_input |=> o_state == 2'b00;
    endproperty
    a_gate: assert property (p_gate) else $error("inactive enable not obeyed");
    property p_settle;
        o_state == 2'b10 && $past(o_state) == 2'b01 |-> $past(settle_cnt) >= $past(init_need);
    endproperty
    a_settle: assert property (p_settle) else $error("output without settling");
    property p_low; $rose(o_load_threshold_output_function) && !$past(i_cfg.mode) |-> $past(below);
    endproperty
    a_low: assert property (p_low) else $error("low mode asserted without underload");
    property p_high; $rose(o_load_threshold_output_function) && $past(i_cfg.mode) |-> $past(above);
    endproperty
    a_high: assert property (p_high) else $error("high mode asserted without overload");
    property p_hold; $rose(o_load_threshold_output_function) |-> $past(run) + 1 >= $past(need);
    endproperty
    a_hold: assert property (p_hold) else $error("output asserted before delay");
    property p_rel; $fell(o_load_threshold_output_function) && o_state == 2'b10 |-> $past(rel);
    endproperty
    a_rel: assert property (p_rel) else $error("release without condition");
    property p_restart; o_state == 2'b10 && !want |=> o_state != 2'b11; endproperty
    a_restart: assert property (p_restart) else $error("asserted on lapsed condition");
    c_low: cover property ($rose(o_load_threshold_output_function) && !i_cfg.mode);
    c_high: cover property ($rose(o_load_threshold_output_function) && i_cfg.mode);
    c_settle: cover property (o_state == 2'b01);
endmodule : load_threshold_monitor_props
bind load_threshold_monitor load_threshold_monitor_props #(.TICK_CYCLES(TICK_CYCLES))
    i_load_threshold_monitor_props (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_cfg(i_cfg),
    .i_enable_configured(i_enable_configured),
    .i_load_monitor_enable_input(i_load_monitor_enable_input),
    .i_active_power(i_active_power), .o_state(o_state),
    .o_load_threshold_output_function(o_load_threshold_output_function));

/* bench/load_threshold_monitor_test.sv */
/* Self-checking bench for the load threshold monitor. Assumes a 4 cycle second. */
`timescale 1ns/1ps
module load_threshold_monitor_test;
    localparam int TICK = 4;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    load_threshold_pkg::monitor_cfg_t cfg;
    logic en_cfg = 1'b0;
    logic en = 1'b0;
    logic [15:0] base = 16'h01f4;
    logic [15:0] power;
    logic out;
    logic [1:0] state;
    logic [31:0] r = 32'h0000_d5a6;
    int mismatches = 0;
    int checks_done = 0;
    always #4 i_ref_clk = ~i_ref_clk;
    load_threshold_monitor #(.TICK_CYCLES(TICK)) i_load_threshold_monitor (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_cfg(cfg), .i_enable_configured(en_cfg),
        .i_load_monitor_enable_input(en), .i_active_power(power),
        .o_load_threshold_output_function(out), .o_state(state));
    load_switch_model i_load_switch_model (
        .i_switch(out), .i_mode(cfg.mode), .i_base_power(base), .o_power(power));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Disabled for both zero, equal or inverted thresholds, idle otherwise.
    function automatic logic [1:0] exp_state(input logic [7:0] lo, input logic [7:0] hi);
        return (lo >= hi) ? 2'b00 : 2'b10;
    endfunction : exp_state
    task automatic wt(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : wt
    // Compares the state in mid-cycle, where it has settled.
    task automatic chk_state(input logic [1:0] exp);
        @(negedge i_ref_clk);
        checks_done++;
        if (state !== exp) begin
            mismatches++;
            $display("ERROR at %0t: state %b, expected %b", $time, state, exp);
        end
    endtask : chk_state
    // Compares the output, then returns on a rising edge so the next drive lands there.
    task automatic chk_out(input logic exp);
        checks_done++;
        if (out !== exp) begin
            mismatches++;
            $display("ERROR at %0t: output %b, expected %b", $time, out, exp);
        end
        @(posedge i_ref_clk);
    endtask : chk_out
    task automatic test_done();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // The run should need well under a thousand cycles.
    initial begin
        #160000;
        mismatches++;
        test_done();
    end
    initial begin
        cfg = '{1'b0, 8'h14, 8'h50, 16'h0003, 16'h0002, 16'h0001, 16'h03e8};
        wt(3);
        i_arst_n <= 1'b1;
        wt(3);
        chk_state(2'b10);
        chk_out(1'b0);
        base <= 16'h0064; wt(5); base <= 16'h01f4; wt(3); base <= 16'h0064;
        wt(7);
        chk_state(2'b10);
        chk_out(1'b0);
        wt(5);
        chk_state(2'b11);
        chk_out(1'b1);
        base <= 16'h02ee; wt(7);
        chk_state(2'b10);
        chk_out(1'b0);
        cfg.mode <= 1'b1; base <= 16'h0384; wt(7);
        chk_state(2'b11);
        chk_out(1'b1);
        base <= 16'h0064; wt(5);
        chk_state(2'b11);
        chk_out(1'b1);
        wt(6);
        chk_state(2'b10);
        chk_out(1'b0);
        en_cfg <= 1'b1; wt(2);
        chk_state(2'b00);
        chk_out(1'b0);
        base <= 16'h0384; en <= 1'b1; wt(3);
        chk_state(2'b01);
        chk_out(1'b0);
        wt(8);
        chk_state(2'b01);
        chk_out(1'b0);
        wt(12);
        chk_state(2'b11);
        chk_out(1'b1);
        en <= 1'b0; wt(2);
        chk_state(2'b00);
        chk_out(1'b0);
        en_cfg <= 1'b0; base <= 16'h0000; cfg.low_delay_s <= 16'h0064;
        for (int k = 0; k < 20; k++) begin
            r = xs(r);
            if (k == 0) r[13:0] = 14'h0000;
            cfg.low_pct <= {2'b00, r[5:0]};
            cfg.high_pct <= {2'b00, r[13:8]};
            cfg.mode <= r[16];
            wt(3);
            chk_state(exp_state({2'b00, r[5:0]}, {2'b00, r[13:8]}));
            chk_out(1'b0);
        end
        test_done();
    end
endmodule : load_threshold_monitor_test
